// ### rtl/uip_pkg.sv
// Constants for the interrupt, port and counter register group
package uip_pkg;
   // Register offsets on the four-bit address
   localparam logic [3:0] ADR_INPUT_CHANGE = 4'h4; // Read
   localparam logic [3:0] ADR_AUX_CONTROL = 4'h4; // Write
   localparam logic [3:0] ADR_IRQ_STATUS = 4'h5; // Read
   localparam logic [3:0] ADR_IRQ_MASK = 4'h5; // Write
   localparam logic [3:0] ADR_COUNT_HIGH = 4'h6; // Read
   localparam logic [3:0] ADR_COUNT_LOW = 4'h7; // Read
   localparam logic [3:0] ADR_VECTOR = 4'hC; // Read and write
   localparam logic [3:0] ADR_INPUT_LEVEL = 4'hD; // Read
   localparam logic [3:0] ADR_CT_START = 4'hE; // Read
   localparam logic [3:0] ADR_OUT_SET_LOW = 4'hE; // Write
   localparam logic [3:0] ADR_CT_STOP = 4'hF; // Read
   localparam logic [3:0] ADR_OUT_SET_HIGH = 4'hF; // Write
   // Values after reset
   localparam logic [7:0] RST_VECTOR = 8'h0F;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_AUX = 8'h00;
   localparam logic [7:0] RST_OUT_PORT = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   // Cycles for the input synchroniser to settle after reset
   localparam int IP_SETTLE = 5;
   // Status bit positions
   localparam int BIT_TXR_A = 0;
   localparam int BIT_RX_A = 1;
   localparam int BIT_BRK_A = 2;
   localparam int BIT_CT = 3;
   localparam int BIT_TXR_B = 4;
   localparam int BIT_RX_B = 5;
   localparam int BIT_BRK_B = 6;
   localparam int BIT_IN_CHG = 7;
   // Aux control and channel mode one fields
   localparam int AUX_TIMER_BIT = 6;
   localparam int MODE_RX_SEL_BIT = 6;
endpackage

// ### rtl/uip_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module uip_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_sys_clk, // System clock
   input wire logic i_sys_rst, // Sync reset, high
   input wire logic [W-1:0] i_pin, // Raw pin level
   output logic [W-1:0] o_level // Filtered level
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // Shift chain, first stage read only by second
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
      end else begin
         s1_reg <= i_pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Accept a bit once stages two and three agree
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_level <= RST_VAL;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               o_level[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule

// ### rtl/uip_regs.sv
// Interrupt, input/output port and counter register group
`timescale 1ns/10ps
module uip_regs (
   input wire logic i_sys_clk, // System clock
   input wire logic i_sys_rst, // Sync reset, high
   input wire logic i_cs_n, // Chip select pin
   input wire logic i_rw, // High read, low write
   input wire logic [3:0] i_addr, // Register address
   input wire logic [7:0] i_data, // Write data pins
   output logic [7:0] o_data, // Read data pins
   output logic o_data_oe, // Data pins driven
   input wire logic i_irq_ack_n, // Interrupt acknowledge
   output logic o_irq_n, // Interrupt request, low
   output logic [7:0] o_irq_status, // Unmasked status
   input wire logic [6:0] i_input_pin, // Input port pins
   input wire logic [7:0] i_output_gp, // 1 = pin general purpose
   output logic [7:0] o_output_pin, // Output port levels
   output logic [7:0] o_aux_control, // Aux control value
   input wire logic i_tx_ready_a, // Channel A tx ready
   input wire logic i_rx_ready_a, // Channel A rx ready
   input wire logic i_fifo_full_a, // Channel A fifo full
   input wire logic i_break_chg_a, // Channel A break change
   input wire logic [7:0] i_chan_a_mode_one, // Channel A mode one
   input wire logic i_tx_ready_b, // Channel B tx ready
   input wire logic i_rx_ready_b, // Channel B rx ready
   input wire logic i_fifo_full_b, // Channel B fifo full
   input wire logic i_break_chg_b, // Channel B break change
   input wire logic [7:0] i_chan_b_mode_one, // Channel B mode one
   input wire logic i_ct_terminal, // Terminal count pulse
   input wire logic i_ct_out, // Timer output level
   input wire logic [15:0] i_count_value, // Current count
   output logic o_ct_start, // Start command pulse
   output logic o_ct_stop // Stop command pulse
);
   import uip_pkg::*;

   logic cs_n_s;
   logic ack_n_s;
   logic [6:0] ip_s;
   logic [1:0] strobe_s;
   logic [IP_SETTLE-1:0] ip_arm_reg;
   logic cs_prev_reg;
   logic ack_prev_reg;
   logic cyc_reg;
   logic ack_reg;
   logic rw_reg;
   logic acc_start;
   logic ack_start;
   logic rd_acc;
   logic wr_acc;
   logic [7:0] mask_reg;
   logic [7:0] aux_reg;
   logic [7:0] vector_reg;
   logic [7:0] out_port_reg;
   logic [7:0] out_port_next;
   logic [3:0] ip_prev_reg;
   logic [3:0] delta_reg;
   logic [3:0] ip_change;
   logic ct_flag_reg;
   logic ct_out_prev_reg;
   logic ct_event;
   logic [7:0] status;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_mux;
   logic start_reg;
   logic stop_reg;

   // Receive condition chosen by mode bit
   function automatic logic rx_sel(input logic [7:0] mode,
                                   input logic rdy, input logic full);
      return mode[MODE_RX_SEL_BIT] ? full : rdy;
   endfunction

   // Pin synchronisers for bus strobes
   uip_sync3 #(.W(2), .RST_VAL(2'b11)) u_sync_bus (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_pin({i_irq_ack_n, i_cs_n}),
      .o_level(strobe_s)
   );

   // Split synchronised strobes
   assign cs_n_s = strobe_s[0];
   assign ack_n_s = strobe_s[1];

   // Pin synchronisers for the input port
   uip_sync3 #(.W(7), .RST_VAL(7'h00)) u_sync_ip (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_pin(i_input_pin),
      .o_level(ip_s)
   );

   // Falling edges of select and acknowledge
   assign acc_start = cs_prev_reg & ~cs_n_s;
   assign ack_start = ack_prev_reg & ~ack_n_s;
   assign rd_acc = acc_start & i_rw;
   assign wr_acc = acc_start & ~i_rw;

   // Bus cycle tracking
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cs_prev_reg <= 1'b1;
         ack_prev_reg <= 1'b1;
         cyc_reg <= 1'b0;
         ack_reg <= 1'b0;
         rw_reg <= 1'b1;
      end else begin
         cs_prev_reg <= cs_n_s;
         ack_prev_reg <= ack_n_s;
         if (acc_start) begin
            cyc_reg <= 1'b1;
            rw_reg <= i_rw;
         end else if (cs_n_s) begin
            cyc_reg <= 1'b0;
         end
         if (ack_start) begin
            ack_reg <= 1'b1;
         end else if (ack_n_s) begin
            ack_reg <= 1'b0;
         end
      end
   end

   // Host-written control registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         mask_reg <= RST_MASK;
         aux_reg <= RST_AUX;
         vector_reg <= RST_VECTOR;
      end else if (wr_acc) begin
         case (i_addr)
            ADR_IRQ_MASK: mask_reg <= i_data;
            ADR_AUX_CONTROL: aux_reg <= i_data;
            ADR_VECTOR: vector_reg <= i_data;
            default: ;
         endcase
      end
   end

   // Output port set and reset, general purpose bits only
   always_comb begin
      out_port_next = out_port_reg;
      if (wr_acc && i_addr == ADR_OUT_SET_LOW) begin
         out_port_next = out_port_reg | (i_data & i_output_gp);
      end else if (wr_acc && i_addr == ADR_OUT_SET_HIGH) begin
         out_port_next = out_port_reg & ~(i_data & i_output_gp);
      end
   end

   // Port bits hold until explicitly changed
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         out_port_reg <= RST_OUT_PORT;
      end else begin
         out_port_reg <= out_port_next;
      end
   end

   // Input change detection, set wins over read clear
   // No false change while the synchroniser leaves its reset value
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ip_arm_reg <= '0;
      end else begin
         ip_arm_reg <= {ip_arm_reg[IP_SETTLE-2:0], 1'b1};
      end
   end
   assign ip_change = (ip_s[3:0] ^ ip_prev_reg) &
                      {4{ip_arm_reg[IP_SETTLE-1]}};
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ip_prev_reg <= 4'h0;
         delta_reg <= 4'h0;
      end else begin
         ip_prev_reg <= ip_s[3:0];
         if (rd_acc && i_addr == ADR_INPUT_CHANGE) begin
            delta_reg <= ip_change;
         end else begin
            delta_reg <= delta_reg | ip_change;
         end
      end
   end

   // Counter event per mode
   assign ct_event = aux_reg[AUX_TIMER_BIT] ?
                     (i_ct_out & ~ct_out_prev_reg) : i_ct_terminal;

   // Counter flag, set wins over stop clear
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ct_flag_reg <= 1'b0;
         ct_out_prev_reg <= 1'b0;
      end else begin
         ct_out_prev_reg <= i_ct_out;
         if (ct_event) begin
            ct_flag_reg <= 1'b1;
         end else if (rd_acc && i_addr == ADR_CT_STOP) begin
            ct_flag_reg <= 1'b0;
         end
      end
   end

   // Status vector from sources
   always_comb begin
      status = 8'h00;
      status[BIT_TXR_A] = i_tx_ready_a;
      status[BIT_RX_A] = rx_sel(i_chan_a_mode_one, i_rx_ready_a,
                                i_fifo_full_a);
      status[BIT_BRK_A] = i_break_chg_a;
      status[BIT_CT] = ct_flag_reg;
      status[BIT_TXR_B] = i_tx_ready_b;
      status[BIT_RX_B] = rx_sel(i_chan_b_mode_one, i_rx_ready_b,
                                i_fifo_full_b);
      status[BIT_BRK_B] = i_break_chg_b;
      status[BIT_IN_CHG] = |(delta_reg & aux_reg[3:0]);
   end

   // Interrupt pin and unmasked status
   assign o_irq_n = ~|(status & mask_reg);
   assign o_irq_status = status;

   // Read data selection
   always_comb begin
      rd_mux = 8'h00;
      case (i_addr)
         ADR_INPUT_CHANGE: rd_mux = {delta_reg, ip_s[3:0]};
         ADR_IRQ_STATUS: rd_mux = status;
         ADR_COUNT_HIGH: rd_mux = i_count_value[15:8];
         ADR_COUNT_LOW: rd_mux = i_count_value[7:0];
         ADR_VECTOR: rd_mux = vector_reg;
         ADR_INPUT_LEVEL: rd_mux = {1'b0, ip_s};
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data latched at access or acknowledge start
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rd_data_reg <= RST_DATA;
      end else if (ack_start) begin
         rd_data_reg <= vector_reg;
      end else if (rd_acc) begin
         rd_data_reg <= rd_mux;
      end
   end

   // Start and stop command pulses
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         start_reg <= 1'b0;
         stop_reg <= 1'b0;
      end else begin
         start_reg <= rd_acc && i_addr == ADR_CT_START;
         stop_reg <= rd_acc && i_addr == ADR_CT_STOP;
      end
   end

   // Output assignments
   assign o_data = rd_data_reg;
   assign o_data_oe = (cyc_reg & rw_reg & ~cs_n_s) | (ack_reg & ~ack_n_s);
   assign o_output_pin = ~out_port_reg;
   assign o_aux_control = aux_reg;
   assign o_ct_start = start_reg;
   assign o_ct_stop = stop_reg;

   // Checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   irq_pin_follows_a: assert property (
      o_irq_n == !(|(status & mask_reg)))
      else $error("interrupt pin disagrees with status and mask");

   mask_zero_quiet_a: assert property (
      mask_reg == 8'h00 |-> o_irq_n)
      else $error("interrupt asserted with all masks clear");

   status_unmasked_a: assert property (
      rd_acc && i_addr == ADR_IRQ_STATUS |=> o_data == $past(status))
      else $error("status read not unmasked");

   chg_flag_set_a: assert property (
      |(ip_change & aux_reg[3:0]) |=> status[BIT_IN_CHG])
      else $error("enabled input change did not set flag");

   chg_read_clear_a: assert property (
      rd_acc && i_addr == ADR_INPUT_CHANGE && ip_change == 4'h0
      |=> delta_reg == 4'h0)
      else $error("input change read did not clear flag");

   level_top_zero_a: assert property (
      rd_acc && i_addr == ADR_INPUT_LEVEL |=> o_data[7] == 1'b0)
      else $error("input level top bit not zero");

   count_bytes_a: assert property (
      rd_acc && i_addr == ADR_COUNT_LOW
      |=> o_data == $past(i_count_value[7:0]))
      else $error("count low byte wrong");

   start_pulse_a: assert property (
      rd_acc && i_addr == ADR_CT_START |=> o_ct_start ##1 !o_ct_start)
      else $error("start command not a single pulse");

   stop_pulse_a: assert property (
      o_ct_stop |-> $past(rd_acc) && $past(i_addr) == ADR_CT_STOP)
      else $error("stop pulse without stop read");

   set_low_a: assert property (
      wr_acc && i_addr == ADR_OUT_SET_LOW
      |=> (o_output_pin & $past(i_data & i_output_gp)) == 8'h00)
      else $error("set low write did not drive low");

   non_gp_hold_a: assert property (
      ((o_output_pin ^ $past(o_output_pin)) & ~$past(i_output_gp)) == 8'h00)
      else $error("alternate function pin changed by port write");

   low_holds_a: assert property (
      $fell(o_output_pin[0]) ##1 !(wr_acc && i_addr == ADR_OUT_SET_HIGH)
      |-> !o_output_pin[0])
      else $error("low output rose without reset write");

   vector_ack_a: assert property (
      ack_start |=> o_data == $past(vector_reg))
      else $error("acknowledge did not present vector");

   ct_flag_set_a: assert property (
      ct_event |=> ct_flag_reg)
      else $error("counter event did not set flag");

   status_read_clean_a: assert property (
      rd_acc && i_addr == ADR_IRQ_STATUS && !ct_event
      |=> ct_flag_reg == $past(ct_flag_reg))
      else $error("status read changed a source");

   cover_status_read: cover property (rd_acc && i_addr == ADR_IRQ_STATUS);
   cover_irq_fire: cover property ($fell(o_irq_n));
   cover_ack: cover property (ack_start ##1 o_data_oe);
   cover_set_reset: cover property (
      wr_acc && i_addr == ADR_OUT_SET_LOW ##[1:50]
      wr_acc && i_addr == ADR_OUT_SET_HIGH);
endmodule

// ### verif/uip_host.sv
// Host processor model driving the chip-select parallel bus
`timescale 1ns/10ps
module uip_host (
   input wire logic i_sys_clk, // System clock
   output logic o_cs_n, // Chip select, low
   output logic o_rw, // High read, low write
   output logic [3:0] o_addr, // Register address
   output logic [7:0] o_data, // Write data
   output logic o_ack_n, // Interrupt acknowledge, low
   input wire logic [7:0] i_data, // Read data
   input wire logic i_oe // Device drives data
);
   // Idle bus
   initial begin
      o_cs_n = 1'b1;
      o_rw = 1'b1;
      o_addr = 4'h0;
      o_data = 8'h00;
      o_ack_n = 1'b1;
   end
   // One access, held until the device answers or the write has landed
   task automatic cycle(input logic rd, input logic ack,
                        input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic tmo);
      tmo = 1'b1;
      q = 8'h00;
      @(negedge i_sys_clk);
      o_rw = rd;
      o_addr = a;
      o_data = d;
      o_ack_n = !ack;
      o_cs_n = ack;
      for (int n = 0; n < 12 && tmo; n++) begin
         @(posedge i_sys_clk);
         if (!rd && n == 5) begin
            tmo = 1'b0;
         end else if (rd && i_oe === 1'b1) begin
            q = i_data;
            tmo = 1'b0;
         end
      end
      // Release; stale data must not linger on the lines
      @(negedge i_sys_clk);
      o_cs_n = 1'b1;
      o_ack_n = 1'b1;
      o_data = ~d;
      repeat (5) @(negedge i_sys_clk);
   endtask
endmodule

// ### verif/uip_regs_test.sv
// Self-checking bench for the register group
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("Error %0t: got %h expected %h", $time, a, b); end end
module uip_regs_test;
   import uip_pkg::*;
   typedef struct {
      logic [6:0] pin;
      logic [15:0] cnt;
      logic [3:0] a;
      logic [7:0] e;
   } uip_row_s;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cs_n, rw, ack_n, oe, irq_n, ct_start, ct_stop;
   logic ct_term = 1'b0;
   logic ct_out = 1'b0;
   logic [1:0] ff = 2'b00;
   logic [3:0] addr;
   logic [7:0] wdata, dbus, rdata, status, opin, aux;
   logic [7:0] src = 8'h00;
   logic [7:0] gp = 8'h0F;
   logic [7:0] mode_a = 8'h00;
   logic [7:0] mode_b = 8'h00;
   logic [6:0] ipin = 7'h00;
   logic [15:0] cnt = 16'h0000;
   int n_errors = 0;
   int n_checks = 0;
   int n_start = 0;
   int n_stop = 0;
   uip_row_s rows [5] = '{
      '{7'h55, 16'h0000, ADR_INPUT_LEVEL, 8'h55},
      '{7'h7F, 16'h0000, ADR_INPUT_LEVEL, 8'h7F},
      '{7'h2A, 16'hA53C, ADR_COUNT_HIGH, 8'hA5},
      '{7'h2A, 16'hA53C, ADR_COUNT_LOW, 8'h3C},
      '{7'h2A, 16'h1234, 4'h0, 8'h00}
   };
   // Clock
   always #2 sys_clk = ~sys_clk;
   // Count command pulses
   always @(posedge sys_clk) begin
      if (ct_start === 1'b1) n_start++;
      if (ct_stop === 1'b1) n_stop++;
   end
   uip_host host (.i_sys_clk(sys_clk), .o_cs_n(cs_n), .o_rw(rw),
      .o_addr(addr), .o_data(wdata), .o_ack_n(ack_n), .i_data(dbus),
      .i_oe(oe));
   uip_regs dut (.i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_cs_n(cs_n),
      .i_rw(rw), .i_addr(addr), .i_data(wdata), .o_data(dbus),
      .o_data_oe(oe), .i_irq_ack_n(ack_n), .o_irq_n(irq_n),
      .o_irq_status(status), .i_input_pin(ipin), .i_output_gp(gp),
      .o_output_pin(opin), .o_aux_control(aux), .i_tx_ready_a(src[0]),
      .i_rx_ready_a(src[1]), .i_fifo_full_a(ff[0]),
      .i_break_chg_a(src[2]), .i_chan_a_mode_one(mode_a),
      .i_tx_ready_b(src[4]), .i_rx_ready_b(src[5]), .i_fifo_full_b(ff[1]),
      .i_break_chg_b(src[6]), .i_chan_b_mode_one(mode_b),
      .i_ct_terminal(ct_term), .i_ct_out(ct_out), .i_count_value(cnt),
      .o_ct_start(ct_start), .o_ct_stop(ct_stop));
   // Verdict and end of run
   task automatic end_sim;
      if (n_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Bus access with timeout handling
   task automatic bus(input logic rd, input logic ack,
                      input logic [3:0] a, input logic [7:0] d);
      logic tmo;
      host.cycle(rd, ack, a, d, rdata, tmo);
      if (tmo) begin
         n_errors++;
         $display("Error %0t: no answer", $time);
         end_sim();
      end
   endtask
   // Reset and check the values it leaves
   task automatic reset_chk;
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      `CHK({irq_n, status, opin}, {1'b1, 8'h00, 8'hFF});
      bus(1'b1, 1'b1, 4'h0, 8'h00);
      `CHK(rdata, 8'h0F);
   endtask
   // Main sequence
   initial begin
      reset_chk();
      foreach (rows[i]) begin
         ipin = rows[i].pin;
         cnt = rows[i].cnt;
         repeat (6) @(negedge sys_clk);
         bus(1'b1, 1'b0, rows[i].a, 8'h00);
         `CHK(rdata, rows[i].e);
      end
      for (int i = 0; i < 7; i++) begin
         if (i == BIT_CT) continue;
         src = 8'h01 << i;
         bus(1'b0, 1'b0, ADR_IRQ_MASK, ~src);
         `CHK({irq_n, status}, {1'b1, src});
         bus(1'b0, 1'b0, ADR_IRQ_MASK, src);
         `CHK(irq_n, 1'b0);
         bus(1'b1, 1'b0, ADR_IRQ_STATUS, 8'h00);
         `CHK(rdata, src);
      end
      bus(1'b0, 1'b0, ADR_IRQ_MASK, 8'h00);
      `CHK(irq_n, 1'b1);
      src = 8'h22;
      mode_a = 8'h40;
      mode_b = 8'h40;
      repeat (2) @(negedge sys_clk);
      `CHK(status, 8'h00);
      ff = 2'b11;
      repeat (2) @(negedge sys_clk);
      `CHK(status, 8'h22);
      src = 8'h00;
      ff = 2'b00;
      ct_term = 1'b1;
      @(negedge sys_clk);
      ct_term = 1'b0;
      @(negedge sys_clk);
      `CHK(status, 8'h08);
      bus(1'b1, 1'b0, ADR_IRQ_STATUS, 8'h00);
      `CHK(status, 8'h08);
      bus(1'b1, 1'b0, ADR_CT_STOP, 8'h00);
      `CHK({n_stop, status}, {32'd1, 8'h00});
      bus(1'b1, 1'b0, ADR_CT_START, 8'h00);
      `CHK({n_start, n_stop}, {32'd1, 32'd1});
      bus(1'b1, 1'b0, ADR_INPUT_CHANGE, 8'h00);
      `CHK(rdata, 8'hFA);
      bus(1'b0, 1'b0, ADR_AUX_CONTROL, 8'h48);
      ct_out = 1'b1;
      repeat (2) @(negedge sys_clk);
      `CHK({aux, status}, {8'h48, 8'h08});
      bus(1'b1, 1'b0, ADR_CT_STOP, 8'h00);
      ipin = 7'h2B;
      repeat (6) @(negedge sys_clk);
      `CHK(status, 8'h00);
      ipin = 7'h23;
      repeat (6) @(negedge sys_clk);
      `CHK(status, 8'h80);
      bus(1'b1, 1'b0, ADR_INPUT_CHANGE, 8'h00);
      `CHK(status, 8'h00);
      bus(1'b0, 1'b0, ADR_OUT_SET_LOW, 8'hFF);
      `CHK(opin, 8'hF0);
      bus(1'b0, 1'b0, ADR_OUT_SET_LOW, 8'h00);
      `CHK(opin, 8'hF0);
      bus(1'b0, 1'b0, ADR_OUT_SET_HIGH, 8'h03);
      `CHK(opin, 8'hF3);
      bus(1'b0, 1'b0, ADR_VECTOR, 8'hA5);
      bus(1'b1, 1'b1, 4'h0, 8'h00);
      `CHK(rdata, 8'hA5);
      reset_chk();
      end_sim();
   end
endmodule
